// [logic/flash_regs_defines.vh]
// shared constants for the flag status and enhanced configuration register block
`ifndef FLASH_REGS_DEFINES_VH
`define FLASH_REGS_DEFINES_VH

// command codes seen on the serial bus
`define CMD_RD_FLAG_STATUS 8'h70
`define CMD_CLR_FLAG_STATUS 8'h50
`define CMD_RD_ENH_CONFIG 8'h65
`define CMD_WR_ENH_CONFIG 8'h61

// enhanced volatile configuration layout and reset value
`define ENH_RESET 8'hdf
`define ENH_WRITE_MASK 8'hdf
`define ENH_QUAD_BIT 7
`define ENH_DUAL_BIT 6
`define ENH_HOLD_BIT 4
`define ENH_VPP_BIT 3
`define ENH_DRIVE_HI 2
`define ENH_DRIVE_LO 0

// flag status bit positions
`define FLAG_READY 7
`define FLAG_ERASE_SUSP 6
`define FLAG_ERASE_ERR 5
`define FLAG_PROG_ERR 4
`define FLAG_VPP_ERR 3
`define FLAG_PROG_SUSP 2
`define FLAG_PROT_ERR 1

// bus protocol codes and data lines driven in each
`define PROTO_EXT 2'h0
`define PROTO_DUAL 2'h1
`define PROTO_QUAD 2'h2
`define OEN_EXT 4'hd
`define OEN_DUAL 4'hc
`define OEN_QUAD 4'h0
`define OEN_NONE 4'hf

// bits moved per serial clock edge and bits per byte
`define STEP_EXT 4'h1
`define STEP_DUAL 4'h2
`define STEP_QUAD 4'h4
`define BYTE_BITS 4'h8

// drive strength codes and their impedance in ohms
`define DRV_90 3'h1
`define DRV_60 3'h2
`define DRV_45 3'h3
`define DRV_20 3'h5
`define DRV_15 3'h6
`define DRV_30 3'h7
`define DRV_RESET 3'h7
`define OHMS_90 7'h5a
`define OHMS_60 7'h3c
`define OHMS_45 7'h2d
`define OHMS_20 7'h14
`define OHMS_15 7'h0f
`define OHMS_30 7'h1e
`define OHMS_NONE 7'h00

// synchroniser reset pattern: select pin idles high, the rest low
`define SYNC_RESET 6'h10

`endif

// [logic/pin_sync2.v]
// two-stage synchroniser for pins arriving from outside the clock domain
`default_nettype none

module pin_sync2 #(
  parameter W = 6,
  parameter [W-1:0] RESET_VAL = {W{1'b0}}
) (
  input wire clk,
  input wire srst,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_q; // first stage, read only by the second stage
  reg [W-1:0] sync_q; // second stage, safe for logic

  // both stages load the idle pattern under reset
  always @(posedge clk) begin
    if (srst) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule // pin_sync2

`default_nettype wire

// [logic/flash_flag_status_and_enh_config_regs.v]
// flag status and enhanced volatile configuration registers behind the serial bus
`include "flash_regs_defines.vh"
`default_nettype none

// Contract
// - decode drive code, reserved codes ignored
// - settings take effect only by config write
// - config read/write work in all protocols
// - bit7 low gives quad, else bit6 dual
// - protocol bits default high, extended single-line
// - ready bit low while program/erase busy
// - ready reflects only program/erase cycles
// - erase suspend bit follows suspend state
// - program suspend bit follows suspend state
// - erase failure sets erase error
// - program failure or illegal 0-to-1 sets error
// - bad program supply sets supply error
// - protected sector or locked area sets flag
// - flags read by own command, all volatile
// - status bits clear themselves
// - error bits clear only by clear command
// - command with error pending reports error
module flash_flag_status_and_enh_config_regs (
  input wire clk,
  input wire srst,
  // serial bus pins, not synchronous to clk
  input wire sclkPin,
  input wire csNPin,
  input wire [3:0] dqIn,
  output wire [3:0] dqOut,
  output wire [3:0] dqOeN,
  // program/erase engine state, synchronous to clk
  input wire peBusy,
  input wire eraseSuspended,
  input wire programSuspended,
  input wire eraseFailEvt,
  input wire programFailEvt,
  input wire zeroToOneEvt,
  input wire highProgramVoltage,
  input wire dataMult64,
  input wire vppInvalidEvt,
  input wire protectViolationEvt,
  // operating configuration
  output wire [1:0] busProtocol,
  output wire [2:0] driveCode,
  output wire [6:0] driveOhms,
  output wire holdResetEnable,
  output wire vppAccelEnable,
  output wire cmdErrorPulse
);

  // serial engine states
  localparam [1:0] ST_CMD = 2'b00; // collecting command byte
  localparam [1:0] ST_WRDATA = 2'b01; // collecting config data byte
  localparam [1:0] ST_READ = 2'b10; // shifting register out
  localparam [1:0] ST_IGNORE = 2'b11; // rest of frame ignored

  // protocol selected by a configuration value
  function [1:0] protoOf;
    input [7:0] cfg;
    begin
      if (!cfg[`ENH_QUAD_BIT]) begin
        protoOf = `PROTO_QUAD; // quad wins, also with both bits low
      end else if (!cfg[`ENH_DUAL_BIT]) begin
        protoOf = `PROTO_DUAL;
      end else begin
        protoOf = `PROTO_EXT;
      end
    end
  endfunction

  // bits moved on each serial clock edge
  function [3:0] stepOf;
    input [1:0] proto;
    begin
      case (proto)
        `PROTO_DUAL: stepOf = `STEP_DUAL;
        `PROTO_QUAD: stepOf = `STEP_QUAD;
        default: stepOf = `STEP_EXT;
      endcase
    end
  endfunction

  // shift received data lines into the byte, msb first
  function [7:0] shiftIn;
    input [7:0] sh;
    input [3:0] dq;
    input [1:0] proto;
    begin
      case (proto)
        `PROTO_DUAL: shiftIn = {sh[5:0], dq[1:0]};
        `PROTO_QUAD: shiftIn = {sh[3:0], dq};
        default: shiftIn = {sh[6:0], dq[0]};
      endcase
    end
  endfunction

  // top bits of a byte placed on the output lines
  function [3:0] topBits;
    input [7:0] b;
    input [1:0] proto;
    begin
      case (proto)
        `PROTO_DUAL: topBits = {2'h0, b[7:6]};
        `PROTO_QUAD: topBits = b[7:4];
        default: topBits = {2'h0, b[7], 1'b0}; // single-line output uses line 1
      endcase
    end
  endfunction

  // active-low enables of the lines driven in each protocol
  function [3:0] oeNOf;
    input [1:0] proto;
    begin
      case (proto)
        `PROTO_DUAL: oeNOf = `OEN_DUAL;
        `PROTO_QUAD: oeNOf = `OEN_QUAD;
        default: oeNOf = `OEN_EXT;
      endcase
    end
  endfunction

  // impedance of a drive code, zero for reserved codes
  function [6:0] ohmsOf;
    input [2:0] code;
    begin
      case (code)
        `DRV_90: ohmsOf = `OHMS_90;
        `DRV_60: ohmsOf = `OHMS_60;
        `DRV_45: ohmsOf = `OHMS_45;
        `DRV_20: ohmsOf = `OHMS_20;
        `DRV_15: ohmsOf = `OHMS_15;
        `DRV_30: ohmsOf = `OHMS_30;
        default: ohmsOf = `OHMS_NONE; // 000 and 100 are reserved
      endcase
    end
  endfunction

  // synchronised pins
  wire sclkS; // serial clock level
  wire csNS; // select level, high when idle
  wire [3:0] dqS; // data line levels

  // every pin passes two flip-flops before any logic
  pin_sync2 #(
    .W(6),
    .RESET_VAL(`SYNC_RESET)
  ) pinSync (
    .clk(clk),
    .srst(srst),
    .din({sclkPin, csNPin, dqIn}),
    .dout({sclkS, csNS, dqS})
  );

  reg sclkPrev_q; // last serial clock level
  reg csNPrev_q; // last select level
  reg [1:0] state_q; // serial engine state
  reg [7:0] rxShift_q; // incoming byte
  reg [3:0] rxCnt_q; // bits received in this byte
  reg [7:0] txShift_q; // remaining bits of outgoing byte
  reg [3:0] txCnt_q; // bits sent of this byte
  reg txSelCfg_q; // read source: config when high, flags when low
  reg [3:0] dqOut_q; // driven data values
  reg [3:0] dqOeN_q; // driven enables, low drives
  reg [7:0] enhCfg_q; // enhanced volatile config contents
  reg [7:0] pendCfg_q; // config byte waiting for frame end
  reg pend_q; // a complete config byte is waiting
  reg [1:0] proto_q; // operating protocol
  reg [2:0] driveCode_q; // operating drive code
  reg [6:0] driveOhms_q; // operating impedance
  reg eraseErr_q; // erase error flag
  reg progErr_q; // program error flag
  reg vppErr_q; // program supply error flag
  reg protErr_q; // protection error flag
  reg cmdErr_q; // one-cycle command error pulse

  // edges of the serial clock inside a selected frame
  wire sclkRise = sclkS & ~sclkPrev_q & ~csNS;
  wire sclkFall = ~sclkS & sclkPrev_q & ~csNS;
  wire csRise = csNS & ~csNPrev_q; // frame end

  // byte assembly on the current protocol width
  wire [3:0] step = stepOf(proto_q);
  wire [7:0] rxByte = shiftIn(rxShift_q, dqS, proto_q);
  wire [3:0] rxCntNext = rxCnt_q + step;
  wire rxDone = sclkRise && (rxCntNext == `BYTE_BITS);

  // command decode for the byte that just completed
  wire errAny = eraseErr_q | progErr_q | vppErr_q | protErr_q;
  wire cmdByte = rxDone && (state_q == ST_CMD);
  wire isRdFlags = (rxByte == `CMD_RD_FLAG_STATUS);
  wire isClrFlags = (rxByte == `CMD_CLR_FLAG_STATUS);
  wire clrReq = cmdByte && isClrFlags;
  wire cmdErrSet = cmdByte && errAny && !isRdFlags && !isClrFlags;

  // flag status assembled from live state and sticky errors
  wire [7:0] flagStatus; // nothing here survives a reset
  assign flagStatus[`FLAG_READY] = ~peBusy;
  assign flagStatus[`FLAG_ERASE_SUSP] = eraseSuspended;
  assign flagStatus[`FLAG_ERASE_ERR] = eraseErr_q;
  assign flagStatus[`FLAG_PROG_ERR] = progErr_q;
  assign flagStatus[`FLAG_VPP_ERR] = vppErr_q;
  assign flagStatus[`FLAG_PROG_SUSP] = programSuspended;
  assign flagStatus[`FLAG_PROT_ERR] = protErr_q;
  assign flagStatus[0] = 1'b0; // reserved

  // error set terms
  wire eraseSet = eraseFailEvt;
  wire progSet = programFailEvt | (zeroToOneEvt & highProgramVoltage & dataMult64);
  wire vppSet = vppInvalidEvt;
  wire protSet = protectViolationEvt | cmdErrSet;

  // next error values: a set in the clear cycle wins
  wire eraseErr_d = (eraseErr_q & ~clrReq) | eraseSet;
  wire progErr_d = (progErr_q & ~clrReq) | progSet;
  wire vppErr_d = (vppErr_q & ~clrReq) | vppSet;
  wire protErr_d = (protErr_q & ~clrReq) | protSet;

  // byte source for reads
  wire [7:0] txSrc = txSelCfg_q ? enhCfg_q : flagStatus;

  // edge history of the synchronised pins
  always @(posedge clk) begin
    if (srst) begin
      sclkPrev_q <= 1'b0;
      csNPrev_q <= 1'b1;
    end else begin
      sclkPrev_q <= sclkS;
      csNPrev_q <= csNS;
    end
  end

  // sticky error flags and command error pulse
  always @(posedge clk) begin
    if (srst) begin
      eraseErr_q <= 1'b0;
      progErr_q <= 1'b0;
      vppErr_q <= 1'b0;
      protErr_q <= 1'b0;
      cmdErr_q <= 1'b0;
    end else begin
      eraseErr_q <= eraseErr_d;
      progErr_q <= progErr_d;
      vppErr_q <= vppErr_d;
      protErr_q <= protErr_d;
      cmdErr_q <= cmdErrSet;
    end
  end

  // receive side: command and config data bytes
  always @(posedge clk) begin
    if (srst) begin
      state_q <= ST_CMD;
      rxShift_q <= 8'h00;
      rxCnt_q <= 4'h0;
      txSelCfg_q <= 1'b0;
      pendCfg_q <= `ENH_RESET;
      pend_q <= 1'b0;
    end else if (csNS) begin
      // idle between frames: restart byte assembly
      state_q <= ST_CMD;
      rxCnt_q <= 4'h0;
      if (csRise) begin
        pend_q <= 1'b0; // the waiting byte is applied at this edge
      end
    end else if (sclkRise) begin
      rxShift_q <= rxByte;
      rxCnt_q <= rxDone ? 4'h0 : rxCntNext;
      if (rxDone) begin
        case (state_q)
          ST_CMD: begin
            if (cmdErrSet) begin
              state_q <= ST_IGNORE; // refused while an error is pending
            end else if (isRdFlags) begin
              state_q <= ST_READ;
              txSelCfg_q <= 1'b0;
            end else if (rxByte == `CMD_RD_ENH_CONFIG) begin
              state_q <= ST_READ;
              txSelCfg_q <= 1'b1;
            end else if (rxByte == `CMD_WR_ENH_CONFIG) begin
              state_q <= ST_WRDATA;
            end else begin
              state_q <= ST_IGNORE; // clear command and unknown codes
            end
          end
          ST_WRDATA: begin
            // fixed-zero bit masked off before it is held
            pendCfg_q <= rxByte & `ENH_WRITE_MASK;
            pend_q <= 1'b1;
            state_q <= ST_IGNORE;
          end
          default: begin
            state_q <= state_q; // reads and ignored frames run to the end
          end
        endcase
      end
    end
  end

  // configuration applied only when a write frame ends
  always @(posedge clk) begin
    if (srst) begin
      enhCfg_q <= `ENH_RESET;
      proto_q <= protoOf(`ENH_RESET);
      driveCode_q <= `DRV_RESET;
      driveOhms_q <= ohmsOf(`DRV_RESET);
    end else if (csRise && pend_q) begin
      enhCfg_q <= pendCfg_q;
      proto_q <= protoOf(pendCfg_q);
      if (ohmsOf(pendCfg_q[`ENH_DRIVE_HI:`ENH_DRIVE_LO]) != `OHMS_NONE) begin
        // reserved drive codes leave the drive as it was
        driveCode_q <= pendCfg_q[`ENH_DRIVE_HI:`ENH_DRIVE_LO];
        driveOhms_q <= ohmsOf(pendCfg_q[`ENH_DRIVE_HI:`ENH_DRIVE_LO]);
      end
    end
  end

  // transmit side: bits change on the falling serial clock
  always @(posedge clk) begin
    if (srst) begin
      txShift_q <= 8'h00;
      txCnt_q <= 4'h0;
      dqOut_q <= 4'h0;
      dqOeN_q <= `OEN_NONE;
    end else if (csNS || state_q != ST_READ) begin
      // lines released outside a read
      txCnt_q <= 4'h0;
      dqOut_q <= 4'h0;
      dqOeN_q <= `OEN_NONE;
    end else if (sclkFall) begin
      dqOeN_q <= oeNOf(proto_q);
      if (txCnt_q == 4'h0) begin
        // byte start: take a fresh copy so repeated reads track state
        dqOut_q <= topBits(txSrc, proto_q);
        txShift_q <= txSrc << step;
      end else begin
        dqOut_q <= topBits(txShift_q, proto_q);
        txShift_q <= txShift_q << step;
      end
      txCnt_q <= ((txCnt_q + step) == `BYTE_BITS) ? 4'h0 : txCnt_q + step;
    end
  end

  // outputs
  assign dqOut = dqOut_q;
  assign dqOeN = dqOeN_q;
  assign busProtocol = proto_q;
  assign driveCode = driveCode_q;
  assign driveOhms = driveOhms_q;
  assign holdResetEnable = enhCfg_q[`ENH_HOLD_BIT];
  assign vppAccelEnable = ~enhCfg_q[`ENH_VPP_BIT];
  assign cmdErrorPulse = cmdErr_q;

endmodule // flash_flag_status_and_enh_config_regs

`default_nettype wire

// [verification/flash_regs_checker.sv]
// assertion checker for the flag status and enhanced configuration block
`default_nettype none
module flash_regs_checker (
  input wire clk,
  input wire srst,
  input wire csNPin,
  input wire [3:0] dqOeN,
  input wire [1:0] busProtocol,
  input wire [2:0] driveCode,
  input wire [6:0] driveOhms,
  input wire holdResetEnable,
  input wire vppAccelEnable,
  input wire cmdErrorPulse
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // impedance that each applied drive code must give
  function automatic logic [6:0] ohmsOf(input logic [2:0] c);
    case (c)
      3'h1: return 7'h5a;
      3'h2: return 7'h3c;
      3'h3: return 7'h2d;
      3'h5: return 7'h14;
      3'h6: return 7'h0f;
      3'h7: return 7'h1e;
      default: return 7'h00;
    endcase
  endfunction
  AST_DRV_OHMS: assert property (driveOhms == ohmsOf(driveCode))
    else $error("drive impedance does not match code");
  AST_NO_RESERVED: assert property (driveCode != 3'h0 && driveCode != 3'h4)
    else $error("reserved drive code applied");
  // settings move only after a frame has ended
  AST_PROTO_HOLD: assert property ($changed(busProtocol) |-> $past(csNPin, 2))
    else $error("protocol changed inside a frame");
  AST_CFG_HOLD: assert property ($changed({driveCode, holdResetEnable, vppAccelEnable}) |->
    $past(csNPin, 2) && $past(csNPin, 1))
    else $error("configuration changed inside a frame");
  // lines driven must match the protocol in use
  AST_OE_LINES: assert property (dqOeN != 4'hf |->
    dqOeN == (busProtocol == 2'h2 ? 4'h0 : (busProtocol == 2'h1 ? 4'hc : 4'hd)))
    else $error("driven lines do not match protocol");
  AST_OE_IDLE: assert property (csNPin [*6] |-> dqOeN == 4'hf)
    else $error("data lines driven while deselected");
  AST_ERR_PULSE: assert property (cmdErrorPulse |-> !$past(csNPin, 3) ##1 !cmdErrorPulse)
    else $error("error report pulse malformed");
  AST_RESET_VALS: assert property ($fell(srst) |-> busProtocol == 2'h0 && driveCode == 3'h7 &&
    holdResetEnable && !vppAccelEnable && dqOeN == 4'hf)
    else $error("wrong values after reset");
  COV_QUAD: cover property (busProtocol == 2'h2);
  COV_QUAD_READ: cover property (dqOeN == 4'h0);
  COV_REFUSED: cover property (cmdErrorPulse);
endmodule // flash_regs_checker
bind flash_flag_status_and_enh_config_regs flash_regs_checker chk (.clk(clk), .srst(srst), .csNPin(csNPin),
  .dqOeN(dqOeN), .busProtocol(busProtocol), .driveCode(driveCode), .driveOhms(driveOhms),
  .holdResetEnable(holdResetEnable), .vppAccelEnable(vppAccelEnable), .cmdErrorPulse(cmdErrorPulse));
`default_nettype wire

// [verification/spi_host_model.sv]
// serial bus host model framing flash register commands
`default_nettype none
module spi_host_model (
  input wire logic clk,
  input wire logic [3:0] dqOut,
  input wire logic [3:0] dqOeN,
  input wire logic [1:0] proto,
  output var logic sclkPin,
  output var logic csNPin,
  output var logic [3:0] dqWire,
  output var logic [7:0] rxByte,
  output var int rxCount
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] hostDq = 4'h0; // values the host puts out
  logic [3:0] hostOe = 4'h0; // lines the host drives
  logic [3:0] floatPat = 4'h5; // released lines change every cycle
  int half = 5; // clk cycles per serial clock half period
  initial begin
    sclkPin = 1'b0;
    csNPin = 1'b1;
    rxByte = 8'h00;
    rxCount = 0;
  end
  // released lines never keep their last value
  always @(posedge clk) floatPat <= ~floatPat;
  // wire level from host and device enables
  always_comb begin
    for (int i = 0; i < 4; i++) dqWire[i] = hostOe[i] ? hostDq[i] : (!dqOeN[i] ? dqOut[i] : floatPat[i]);
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // lines used per serial edge in the protocol in force
  function automatic logic [3:0] laneMask();
    return proto == 2'h2 ? 4'hf : (proto == 2'h1 ? 4'h3 : 4'h1);
  endfunction
  // msb first, data changed while the serial clock is low
  task automatic sendBits(input logic [7:0] b, input int nBits);
    logic [3:0] m;
    m = laneMask();
    for (int i = 8 - $countones(m); i >= 8 - nBits; i -= $countones(m)) begin
      hostDq <= 4'(b >> i) & m;
      hostOe <= m;
      tick(half);
      sclkPin <= 1'b1;
      tick(half);
      sclkPin <= 1'b0;
    end
  endtask
  // sample device lines at each rise
  task automatic recvByte();
    logic [3:0] m;
    logic [7:0] r;
    m = laneMask();
    r = 8'h00;
    hostOe <= 4'h0;
    for (int i = 0; i < 8; i += $countones(m)) begin
      tick(half);
      r = (r << $countones(m)) | 8'(m == 4'h1 ? {3'b000, dqWire[1]} : dqWire & m);
      sclkPin <= 1'b1;
      tick(half);
      sclkPin <= 1'b0;
    end
    rxByte <= r;
    rxCount <= rxCount + 1;
  endtask
  // one command per frame; flags only through their own read command
  task automatic frame(input logic [7:0] cmd, input logic [7:0] wr, input int wrBits, input int nRd);
    csNPin <= 1'b0;
    tick(half);
    sendBits(cmd, 8);
    if (wrBits > 0) sendBits(wr, wrBits);
    repeat (nRd) recvByte();
    hostOe <= 4'h0;
    tick(half);
    csNPin <= 1'b1;
    tick(4 * half);
  endtask
endmodule // spi_host_model
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the flag status and enhanced configuration block
`include "flash_regs_defines.vh"
`default_nettype none
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, srst = 1'b1, peBusy = 1'b0, eraseSusp = 1'b0, progSusp = 1'b0, hv = 1'b0, m64 = 1'b0;
  logic [4:0] evt = 5'h0; // erase fail, program fail, zero-to-one, supply, protection
  logic [1:0] hostProto = 2'h0; // protocol the host believes in force
  wire sclkPin, csNPin, holdResetEnable, vppAccelEnable, cmdErrorPulse;
  wire [3:0] dqWire, dqOut, dqOeN;
  wire [1:0] busProtocol;
  wire [2:0] driveCode;
  wire [6:0] driveOhms;
  wire [7:0] rxByte;
  int rxCount, failures = 0, checks_done = 0, seen = 0, pulses = 0;
  logic [7:0] expQ[$]; // read bytes still awaited
  flash_flag_status_and_enh_config_regs dut (.clk(clk), .srst(srst), .sclkPin(sclkPin), .csNPin(csNPin),
    .dqIn(dqWire), .dqOut(dqOut), .dqOeN(dqOeN), .peBusy(peBusy), .eraseSuspended(eraseSusp),
    .programSuspended(progSusp), .eraseFailEvt(evt[0]), .programFailEvt(evt[1]), .zeroToOneEvt(evt[2]),
    .highProgramVoltage(hv), .dataMult64(m64), .vppInvalidEvt(evt[3]), .protectViolationEvt(evt[4]),
    .busProtocol(busProtocol), .driveCode(driveCode), .driveOhms(driveOhms),
    .holdResetEnable(holdResetEnable), .vppAccelEnable(vppAccelEnable), .cmdErrorPulse(cmdErrorPulse));
  spi_host_model host (.clk(clk), .dqOut(dqOut), .dqOeN(dqOeN), .proto(hostProto), .sclkPin(sclkPin),
    .csNPin(csNPin), .dqWire(dqWire), .rxByte(rxByte), .rxCount(rxCount));
  initial begin
    forever #4 clk = ~clk;
  end
  // compare each received byte with the oldest note
  always @(posedge clk) begin
    if (cmdErrorPulse === 1'b1) pulses++;
    if (rxCount != seen) begin
      seen = rxCount;
      if (expQ.size() == 0) `CHK(1'b0, 1'b1, "unexpected read byte")
      else `CHK(rxByte, expQ.pop_front(), "read byte")
    end
  end
  function automatic logic [6:0] ohms(input logic [2:0] c);
    case (c)
      3'h1: return 7'h5a;
      3'h2: return 7'h3c;
      3'h3: return 7'h2d;
      3'h5: return 7'h14;
      3'h6: return 7'h0f;
      default: return 7'h1e;
    endcase
  endfunction
  task automatic rd(input logic [7:0] cmd, input logic [7:0] e);
    expQ.push_back(e);
    host.frame(cmd, 8'h00, 0, 1);
  endtask
  task automatic conclude();
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    logic [7:0] v;
    logic [7:0] pv[4] = '{8'h7f, 8'h3f, 8'hbf, 8'hff};
    logic [1:0] pe[4] = '{2'h2, 2'h2, 2'h1, 2'h0};
    int ev[6] = '{0, 1, 2, 2, 3, 4};
    logic [1:0] gate[6] = '{2'h0, 2'h0, 2'h3, 2'h2, 2'h0, 2'h0};
    logic [7:0] fb[6] = '{8'h20, 8'h10, 8'h10, 8'h00, 8'h08, 8'h02};
    logic [2:0] cur;
    logic [1:0] r;
    int n;
    v = 8'($urandom(71));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK({busProtocol, driveCode, driveOhms, holdResetEnable, vppAccelEnable}, 14'h0e7a, "reset")
    rd(`CMD_RD_ENH_CONFIG, 8'hdf);
    rd(`CMD_RD_FLAG_STATUS, 8'h80);
    // every drive code, reserved ones leave the applied code alone
    cur = 3'h7;
    for (int c = 0; c < 8; c++) begin
      r = 2'($urandom());
      v = {3'b110, r, 3'(c)};
      host.frame(`CMD_WR_ENH_CONFIG, v, 8, 0);
      if (c != 0 && c != 4) cur = 3'(c);
      `CHK({driveCode, driveOhms}, {cur, ohms(cur)}, "drive decode")
      `CHK({holdResetEnable, vppAccelEnable}, {r[1], !r[0]}, "config bits")
      rd(`CMD_RD_ENH_CONFIG, v);
    end
    // a partial data byte changes nothing
    host.frame(`CMD_WR_ENH_CONFIG, 8'h11, 4, 0);
    `CHK({busProtocol, driveCode}, {2'h0, cur}, "partial byte")
    foreach (pv[i]) begin
      host.frame(`CMD_WR_ENH_CONFIG, pv[i], 8, 0);
      hostProto = pe[i];
      `CHK(busProtocol, pe[i], "protocol select")
      rd(`CMD_RD_ENH_CONFIG, pv[i] & 8'hdf);
    end
    // live status levels, read with a slow serial clock
    host.half = 8;
    for (int k = 0; k < 8; k++) begin
      r = 2'($urandom());
      v = 8'($urandom());
      peBusy <= r[0];
      eraseSusp <= r[1];
      progSusp <= v[0];
      rd(`CMD_RD_FLAG_STATUS, {!r[0], r[1], 3'b000, v[0], 2'b00});
    end
    host.half = 5;
    peBusy <= 1'b0;
    eraseSusp <= 1'b0;
    progSusp <= 1'b0;
    rd(`CMD_RD_FLAG_STATUS, 8'h80);
    // each error source, sticky until cleared, refusal while pending
    for (int e = 0; e < 6; e++) begin
      evt <= 5'(1 << ev[e]);
      {hv, m64} <= gate[e];
      @(posedge clk);
      evt <= 5'h0;
      rd(`CMD_RD_FLAG_STATUS, 8'h80 | fb[e]);
      if (fb[e] != 8'h00) begin
        rd(`CMD_RD_FLAG_STATUS, 8'h80 | fb[e]);
        n = pulses;
        host.frame(`CMD_RD_ENH_CONFIG, 8'h00, 0, 0);
        `CHK(pulses, n + 1, "error report pulse")
        rd(`CMD_RD_FLAG_STATUS, 8'h82 | fb[e]);
        host.frame(`CMD_CLR_FLAG_STATUS, 8'h00, 0, 0);
        rd(`CMD_RD_FLAG_STATUS, 8'h80);
      end
    end
    // second reset wipes the volatile settings
    host.frame(`CMD_WR_ENH_CONFIG, 8'h7a, 8, 0);
    `CHK({busProtocol, driveCode}, 5'h12, "settings before reset")
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    hostProto = 2'h0;
    repeat (4) @(posedge clk);
    `CHK({busProtocol, driveCode}, 5'h07, "second reset")
    rd(`CMD_RD_ENH_CONFIG, 8'hdf);
    repeat (10) @(posedge clk);
    `CHK(expQ.size(), 0, "missing read bytes")
    conclude();
  end
endmodule // tb
`default_nettype wire
